/* File: include/crcc_pkg.sv */
package crcc_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CON1     = 8'h00;
	localparam logic [7:0] ADDR_CON2     = 8'h04;
	localparam logic [7:0] ADDR_POLY     = 8'h08;
	localparam logic [7:0] ADDR_DATA     = 8'h0c;
	localparam logic [7:0] ADDR_RESULT   = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int EN_BIT    = 15;
	localparam int SIDL_BIT  = 13;
	localparam int VW_LSB    = 8;
	localparam int FULL_BIT  = 7;
	localparam int EMPTY_BIT = 6;
	localparam int ISEL_BIT  = 5;
	localparam int GO_BIT    = 4;
	localparam int LSBF_BIT  = 3;
	localparam int DW_LSB    = 8;
	localparam int POLY_LENGTH_FIELD_LSB  = 0;
	localparam int STAT_CRC  = 0;
	localparam int STAT_FULL = 1;

	// ----------------------------------------------------------------
	// values after reset, depths, answers
	// ----------------------------------------------------------------
	localparam logic [31:0] WORD_RST    = 32'h0000_0000;
	localparam logic [4:0]  FIELD_RST   = 5'h00;
	localparam logic [1:0]  STAT_RST    = 2'h0;
	localparam logic [4:0]  DEPTH_WIDE  = 5'h04;
	localparam logic [4:0]  DEPTH_MID   = 5'h08;
	localparam logic [4:0]  DEPTH_NARR  = 5'h10;
	localparam logic [4:0]  DW_MID_MIN  = 5'h08;
	localparam logic [4:0]  DW_WIDE_MIN = 5'h10;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [2:0]
	{
		CRCC_IDLE  = 3'b001,
		CRCC_LOAD  = 3'b010,
		CRCC_SHIFT = 3'b100
	} crcc_fsm_e;

endpackage

/* File: include/crcc_mem_if.sv */
`timescale 1ns/1ps
interface crcc_mem_if;
	logic        we;
	logic [3:0]  waddr;
	logic [31:0] wdata;
	logic        re;
	logic [3:0]  raddr;
	logic [31:0] rdata;

	modport ctl (output we, waddr, wdata, re, raddr, input rdata);
	modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface

/* File: src/crcc_fifo_mem.sv */
`timescale 1ns/1ps
module crcc_fifo_mem
(
	input  wire logic   clk,    // system clock
	input  wire logic   sys_rst, // async reset, high
	crcc_mem_if.mem     mp      // fifo storage port
);
	typedef struct packed
	{
		logic [15:0][31:0] word;
		logic [31:0]       rdata;
	} crcc_mem_s;

	crcc_mem_s s;
	crcc_mem_s n;

	assign mp.rdata = s.rdata;

	always_comb
	begin
		n = s;
		if (mp.we)
			n.word[mp.waddr] = mp.wdata;
		// read data holds between reads so a stalled load keeps it
		if (mp.re)
			n.rdata = s.word[mp.raddr];
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			s <= '0;
		else
			s <= n;
	end
endmodule

/* File: src/crcc_top.sv */
`timescale 1ns/1ps
module crcc_top
(
	input  wire logic        clk,            // 40 MHz system clock
	input  wire logic        sys_rst,        // async reset, high
	input  wire logic        idle_mode,      // device idle pin
	input  wire logic [7:0]  s_axi_awaddr,   // write address
	input  wire logic        s_axi_awvalid,  // write address valid
	output logic             s_axi_awready,  // write address ready
	input  wire logic [31:0] s_axi_wdata,    // write data
	input  wire logic [3:0]  s_axi_wstrb,    // byte strobes
	input  wire logic        s_axi_wvalid,   // write data valid
	output logic             s_axi_wready,   // write data ready
	output logic [1:0]       s_axi_bresp,    // write response
	output logic             s_axi_bvalid,   // write response valid
	input  wire logic        s_axi_bready,   // write response ready
	input  wire logic [7:0]  s_axi_araddr,   // read address
	input  wire logic        s_axi_arvalid,  // read address valid
	output logic             s_axi_arready,  // read address ready
	output logic [31:0]      s_axi_rdata,    // read data
	output logic [1:0]       s_axi_rresp,    // read response
	output logic             s_axi_rvalid,   // read data valid
	input  wire logic        s_axi_rready,   // read data ready
	output logic             irq             // level interrupt
);
	typedef struct packed
	{
		logic                awready;
		logic                wready;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
		logic                irq;
		logic                idle_s1;
		logic                idle_s2;
		logic                en;
		logic                sidl;
		logic                isel;
		logic                go;
		logic                lsbf;
		logic [4:0]          data_width_field;
		logic [4:0]          poly_length_field;
		logic [31:0]         poly;
		logic [31:0]         hold;
		logic [31:0]         crc;
		logic [31:0]         word;
		logic [5:0]          done;
		logic [4:0]          count;
		logic [3:0]          wr_ptr;
		logic [3:0]          rd_ptr;
		crcc_pkg::crcc_fsm_e fsm;
		logic [1:0]          stat;
		logic [1:0]          mask;
	} crcc_top_s;

	crcc_top_s s;
	crcc_top_s next_s;

	crcc_mem_if mi();

	crcc_fifo_mem crcc_fifo_mem_inst
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.mp      (mi.mem)
	);

	assign s_axi_awready = s.awready;
	assign s_axi_wready  = s.wready;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;
	assign irq           = s.irq;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] crcc_merge(logic [31:0] old, logic [31:0] val,
		logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = val[i*8 +: 8];
		return r;
	endfunction

	// one serial crc step; top term is implied, x0 always taps
	function automatic logic [31:0] crcc_step(logic [31:0] c, logic b,
		logic [31:0] poly, logic [4:0] poly_length_field);
		logic        fb;
		logic [31:0] r;
		fb = b ^ c[poly_length_field];
		r  = {c[30:0], 1'b0};
		if (fb)
			r = r ^ (poly | 32'h0000_0001);
		return r & (32'hffff_ffff >> (5'h1f - poly_length_field));
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic        run;
	logic        push;
	logic        pop;
	logic        hw_clr;
	logic        wr_take;
	logic        rd_take;
	logic        en_rise;
	logic [4:0]  depth;
	logic [5:0]  left;
	logic [4:0]  idx0;
	logic [4:0]  idx1;
	logic [31:0] crc_t;
	logic [31:0] wmerge;
	logic [15:0] con1_rd;

	always_comb
	begin
		next_s  = s;
		push    = 1'b0;
		pop     = 1'b0;
		hw_clr  = 1'b0;
		en_rise = 1'b0;
		crc_t   = s.crc;
		wmerge  = crcc_merge(s.hold, s_axi_wdata, s_axi_wstrb);
		next_s.idle_s1 = idle_mode;
		next_s.idle_s2 = s.idle_s1;
		run = s.en && !(s.sidl && s.idle_s2);
		if (s.data_width_field >= crcc_pkg::DW_WIDE_MIN)
			depth = crcc_pkg::DEPTH_WIDE;
		else if (s.data_width_field >= crcc_pkg::DW_MID_MIN)
			depth = crcc_pkg::DEPTH_MID;
		else
			depth = crcc_pkg::DEPTH_NARR;
		left = 6'({1'b0, s.data_width_field} + 6'h01 - s.done);
		idx0 = s.lsbf ? s.done[4:0] : 5'(s.data_width_field - s.done[4:0]);
		idx1 = s.lsbf ? 5'(s.done[4:0] + 5'h01) : 5'(s.data_width_field - s.done[4:0] - 5'h01);

		// serial shifter; halts with start low or idle stop
		case (s.fsm)
			crcc_pkg::CRCC_IDLE:
			begin
				if (run && s.go && s.count != 5'h00)
				begin
					pop        = 1'b1;
					next_s.fsm = crcc_pkg::CRCC_LOAD;
				end
			end
			crcc_pkg::CRCC_LOAD:
			begin
				if (run)
				begin
					next_s.word = mi.rdata;
					next_s.done = 6'h00;
					next_s.fsm  = crcc_pkg::CRCC_SHIFT;
				end
			end
			crcc_pkg::CRCC_SHIFT:
			begin
				if (run && s.go)
				begin
					crc_t = crcc_step(s.crc, s.word[idx0], s.poly, s.poly_length_field);
					if (left >= 6'h02)
						crc_t = crcc_step(crc_t, s.word[idx1], s.poly, s.poly_length_field);
					next_s.crc  = crc_t;
					next_s.done = 6'(s.done + 6'h02);
					if (left <= 6'h02)
					begin
						if (s.count != 5'h00)
						begin
							pop        = 1'b1;
							next_s.fsm = crcc_pkg::CRCC_LOAD;
						end
						else
						begin
							next_s.fsm = crcc_pkg::CRCC_IDLE;
							next_s.go  = 1'b0;
							hw_clr     = 1'b1;
						end
					end
				end
			end
			default:
				next_s.fsm = crcc_pkg::CRCC_IDLE;
		endcase

		// ------------------------------------------------------------
		// bus write
		// ------------------------------------------------------------
		wr_take = s_axi_awvalid && s_axi_wvalid && !s.bvalid && !s.awready;
		next_s.awready = wr_take;
		next_s.wready  = wr_take;
		if (s.bvalid && s_axi_bready)
			next_s.bvalid = 1'b0;
		if (wr_take)
		begin
			next_s.bvalid = 1'b1;
			next_s.bresp  = crcc_pkg::RESP_OKAY;
			if (s_axi_awaddr == crcc_pkg::ADDR_CON1)
			begin
				// count and flags are not writable
				if (s_axi_wstrb[1])
				begin
					next_s.en   = s_axi_wdata[crcc_pkg::EN_BIT];
					next_s.sidl = s_axi_wdata[crcc_pkg::SIDL_BIT];
					en_rise     = s_axi_wdata[crcc_pkg::EN_BIT] && !s.en;
				end
				if (s_axi_wstrb[0])
				begin
					next_s.isel = s_axi_wdata[crcc_pkg::ISEL_BIT];
					next_s.go   = s_axi_wdata[crcc_pkg::GO_BIT];
					next_s.lsbf = s_axi_wdata[crcc_pkg::LSBF_BIT];
				end
			end
			else if (s_axi_awaddr == crcc_pkg::ADDR_CON2)
			begin
				if (s_axi_wstrb[1])
					next_s.data_width_field = s_axi_wdata[crcc_pkg::DW_LSB +: 5];
				if (s_axi_wstrb[0])
					next_s.poly_length_field = s_axi_wdata[crcc_pkg::POLY_LENGTH_FIELD_LSB +: 5];
			end
			else if (s_axi_awaddr == crcc_pkg::ADDR_POLY)
				next_s.poly = crcc_merge(s.poly, s_axi_wdata, s_axi_wstrb);
			else if (s_axi_awaddr == crcc_pkg::ADDR_DATA)
			begin
				next_s.hold = wmerge;
				// the byte holding the word's top bit completes it
				if (s_axi_wstrb[s.data_width_field[4:3]] && s.en && s.count < depth)
					push = 1'b1;
			end
			else if (s_axi_awaddr == crcc_pkg::ADDR_RESULT)
				next_s.crc = crcc_merge(s.crc, s_axi_wdata, s_axi_wstrb);
			else if (s_axi_awaddr == crcc_pkg::ADDR_IRQ_STAT)
				next_s.stat = s.stat & ~s_axi_wdata[1:0];
			else if (s_axi_awaddr == crcc_pkg::ADDR_IRQ_MASK)
				next_s.mask = s_axi_wdata[1:0];
			else
				next_s.bresp = crcc_pkg::RESP_SLVERR;
		end

		// ------------------------------------------------------------
		// fifo pointers and count
		// ------------------------------------------------------------
		mi.we    = push;
		mi.waddr = s.wr_ptr;
		mi.wdata = wmerge;
		mi.re    = pop;
		mi.raddr = s.rd_ptr;
		if (push)
			next_s.wr_ptr = (5'(s.wr_ptr) + 5'h01 == depth) ? 4'h0 : 4'(s.wr_ptr + 4'h1);
		if (pop)
			next_s.rd_ptr = (5'(s.rd_ptr) + 5'h01 == depth) ? 4'h0 : 4'(s.rd_ptr + 4'h1);
		next_s.count = 5'(s.count + 5'(push) - 5'(pop));

		// events set sticky bits; set wins over a same-cycle clear
		if (s.isel ? hw_clr : (pop && !push && s.count == 5'h01))
			next_s.stat[crcc_pkg::STAT_CRC] = 1'b1;
		if (next_s.count == depth && s.count != depth)
			next_s.stat[crcc_pkg::STAT_FULL] = 1'b1;

		if (en_rise)
		begin
			next_s.fsm    = crcc_pkg::CRCC_IDLE;
			next_s.wr_ptr = 4'h0;
			next_s.rd_ptr = 4'h0;
			next_s.count  = crcc_pkg::FIELD_RST;
			next_s.hold   = crcc_pkg::WORD_RST;
			next_s.word   = crcc_pkg::WORD_RST;
			next_s.crc    = crcc_pkg::WORD_RST;
			next_s.done   = 6'h00;
		end
		if (!next_s.en)
		begin
			next_s.wr_ptr = 4'h0;
			next_s.rd_ptr = 4'h0;
			next_s.count  = crcc_pkg::FIELD_RST;
			next_s.fsm    = crcc_pkg::CRCC_IDLE;
		end
		next_s.irq = |(next_s.stat & next_s.mask);

		// ------------------------------------------------------------
		// bus read
		// ------------------------------------------------------------
		con1_rd = 16'h0000;
		con1_rd[crcc_pkg::EN_BIT]        = s.en;
		con1_rd[crcc_pkg::SIDL_BIT]      = s.sidl;
		con1_rd[crcc_pkg::VW_LSB +: 5]   = s.count;
		con1_rd[crcc_pkg::FULL_BIT]      = (s.count == depth);
		con1_rd[crcc_pkg::EMPTY_BIT]     = (s.count == 5'h00);
		con1_rd[crcc_pkg::ISEL_BIT]      = s.isel;
		con1_rd[crcc_pkg::GO_BIT]        = s.go;
		con1_rd[crcc_pkg::LSBF_BIT]      = s.lsbf;
		rd_take = s_axi_arvalid && !s.rvalid && !s.arready;
		next_s.arready = rd_take;
		if (s.rvalid && s_axi_rready)
			next_s.rvalid = 1'b0;
		if (rd_take)
		begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = crcc_pkg::RESP_OKAY;
			next_s.rdata  = 32'h0000_0000;
			if (s_axi_araddr == crcc_pkg::ADDR_CON1)
				next_s.rdata = {16'h0000, con1_rd};
			else if (s_axi_araddr == crcc_pkg::ADDR_CON2)
				next_s.rdata = {19'h0, s.data_width_field, 3'h0, s.poly_length_field};
			else if (s_axi_araddr == crcc_pkg::ADDR_POLY)
				next_s.rdata = s.poly;
			else if (s_axi_araddr == crcc_pkg::ADDR_DATA)
				next_s.rdata = s.hold;
			else if (s_axi_araddr == crcc_pkg::ADDR_RESULT)
				next_s.rdata = s.crc;
			else if (s_axi_araddr == crcc_pkg::ADDR_IRQ_STAT)
				next_s.rdata = {30'h0, s.stat};
			else if (s_axi_araddr == crcc_pkg::ADDR_IRQ_MASK)
				next_s.rdata = {30'h0, s.mask};
			else
				next_s.rresp = crcc_pkg::RESP_SLVERR;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s     <= '0;
			s.fsm <= crcc_pkg::CRCC_IDLE;
		end
		else
			s <= next_s;
	end
endmodule

/* File: verification/crcc_monitor.sv */
`timescale 1ns/1ps
module crcc_monitor
(
	input wire logic        clk,           // clock
	input wire logic        sys_rst,       // reset
	input wire logic [7:0]  s_axi_araddr,  // read address
	input wire logic        s_axi_arvalid, // read valid
	input wire logic [31:0] s_axi_rdata,   // read data
	input wire logic        s_axi_rvalid,  // data valid
	input wire logic        s_axi_rready,  // data ready
	input wire logic        s_axi_bvalid,  // write response
	input wire logic        irq            // interrupt
);
	logic       con;
	logic [4:0] cnt;
	assign cnt = s_axi_rdata[12:8];
	// address captured at the take edge, before rvalid rises
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
			con <= 1'h0;
		else if (s_axi_arvalid && !s_axi_rvalid)
			con <= s_axi_araddr == crcc_pkg::ADDR_CON1;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_zero;
		s_axi_rvalid && con |-> s_axi_rdata[31:16] == 16'h0 && !s_axi_rdata[14]
			&& s_axi_rdata[2:0] == 3'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("unused bits set");
	property p_cnt;
		s_axi_rvalid && con |-> cnt <= 5'h10;
	endproperty
	a_cnt: assert property (p_cnt) else $error("count too big");
	property p_empty;
		s_axi_rvalid && con |-> s_axi_rdata[6] == (cnt == 5'h0);
	endproperty
	a_empty: assert property (p_empty) else $error("empty flag wrong");
	property p_full;
		s_axi_rvalid && con && s_axi_rdata[7] |-> cnt inside {5'h4, 5'h8, 5'h10};
	endproperty
	a_full: assert property (p_full) else $error("full flag wrong");
	property p_both;
		s_axi_rvalid && con |-> !(s_axi_rdata[7] && s_axi_rdata[6]);
	endproperty
	a_both: assert property (p_both) else $error("full and empty");
	property p_off;
		s_axi_rvalid && con && !s_axi_rdata[15] |-> cnt == 5'h0;
	endproperty
	a_off: assert property (p_off) else $error("count while disabled");
	property p_irq;
		$fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
	endproperty
	a_irq: assert property (p_irq) else $error("irq fell unprompted");
	property p_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
endmodule

/* File: verification/crcc_top_test.sv */
`timescale 1ns/1ps
module crcc_top_test;
	logic        clk = 1'h0;
	logic        sys_rst = 1'h1;
	logic        idle_mode = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 1'h0;
	logic        s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] s_axi_rdata, rv, e;
	int          miscompares = 0;
	int          cmp_count = 0;
	always #12.5 clk = ~clk;
	crcc_top crcc_top_inst (.clk, .sys_rst, .idle_mode, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
	// ----
	// reporting
	// ----
	task automatic print_verdict;
		$display("mismatches %0d comparisons %0d", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic fail(input string m);
		miscompares++;
		$display("ERROR %0t %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x)
			fail($sformatf("got %h expected %h", g, x));
	endtask
	// ----
	// bus master; each task waits one edge first so no signal is set twice
	// ----
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		int   n;
		n = 0;
		tb = 1'h0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!tb && n < 40)
		begin
			@(negedge clk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tb = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge clk);
			if (ta)
				s_axi_awvalid <= 1'h0;
			if (tw)
				s_axi_wvalid <= 1'h0;
			n++;
		end
		s_axi_bready <= 1'h0;
		if (!tb)
		begin
			fail("write timeout");
			print_verdict;
		end
	endtask
	// lag holds rready low for that many edges so held read data can be watched
	task automatic axi_rd(input logic [7:0] a, input int lag = 0);
		logic ta, tr;
		int   n;
		n = 0;
		tr = 1'h0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= (lag == 0);
		while (!tr && n < 40)
		begin
			@(negedge clk);
			ta = s_axi_arready;
			tr = s_axi_rvalid && s_axi_rready;
			rv = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge clk);
			if (ta)
				s_axi_arvalid <= 1'h0;
			n++;
			if (n >= lag && !tr)
				s_axi_rready <= 1'h1;
		end
		s_axi_rready <= 1'h0;
		if (!tr)
		begin
			fail("read timeout");
			print_verdict;
		end
	endtask
	task automatic wait_go;
		int n;
		n = 0;
		rv = 32'h10;
		while (rv[4] && n < 20)
		begin
			axi_rd(crcc_pkg::ADDR_CON1);
			n++;
		end
		if (rv[4])
		begin
			fail("start never cleared");
			print_verdict;
		end
	endtask
	// ----
	// scenarios
	// ----
	localparam logic [31:0] POLY = 32'h04c1_1db7;
	// bit-serial model of a full-width engine: x0 always taps, top term implied
	function automatic logic [31:0] ref_crc(input logic [31:0] c, input logic [31:0] w,
		input logic lsbf);
		logic b;
		for (int i = 0; i < 32; i++)
		begin
			b = lsbf ? w[i] : w[31 - i];
			c = {c[30:0], 1'b0} ^ ((b ^ c[31]) ? (POLY | 32'h1) : 32'h0);
		end
		return c;
	endfunction
	task automatic t_reset;
		axi_rd(crcc_pkg::ADDR_CON1, 3);
		chk(rv, 32'h0000_0040);
		chk({30'h0, rs}, {30'h0, crcc_pkg::RESP_OKAY});
		chk({31'h0, irq}, 32'h0);
		axi_wr(8'h1c, 32'hffff_ffff);
		chk({30'h0, rs}, {30'h0, crcc_pkg::RESP_SLVERR});
		axi_rd(8'h1c);
		chk(rv, 32'h0);
		chk({30'h0, rs}, {30'h0, crcc_pkg::RESP_SLVERR});
	endtask
	task automatic t_fields;
		axi_wr(crcc_pkg::ADDR_CON1, 32'hffff_ffef);
		chk({30'h0, rs}, {30'h0, crcc_pkg::RESP_OKAY});
		axi_rd(crcc_pkg::ADDR_CON1);
		chk(rv, 32'h0000_a068);
		axi_wr(crcc_pkg::ADDR_CON1, 32'h0000_8000);
		axi_rd(crcc_pkg::ADDR_CON1);
		chk(rv, 32'h0000_8040);
	endtask
	task automatic t_fill;
		int i;
		axi_wr(crcc_pkg::ADDR_CON2, 32'h0000_1f1f);
		axi_rd(crcc_pkg::ADDR_CON2);
		chk(rv, 32'h0000_1f1f);
		for (i = 1; i <= 5; i++)
		begin
			axi_wr(crcc_pkg::ADDR_DATA, 32'(i));
			axi_rd(crcc_pkg::ADDR_CON1);
			e = 32'h8000;
			e[12:8] = (i > 4) ? 5'h4 : 5'(i);
			e[7] = i >= 4;
			chk(rv, e);
		end
		axi_rd(crcc_pkg::ADDR_IRQ_STAT);
		chk(rv, 32'h2);
		chk({31'h0, irq}, 32'h0);
		axi_wr(crcc_pkg::ADDR_IRQ_MASK, 32'h3);
		axi_rd(crcc_pkg::ADDR_IRQ_MASK);
		chk(rv, 32'h3);
		chk({31'h0, irq}, 32'h1);
		axi_wr(crcc_pkg::ADDR_IRQ_STAT, 32'h2);
		axi_rd(crcc_pkg::ADDR_IRQ_STAT);
		chk(rv | {31'h0, irq}, 32'h0);
		axi_wr(crcc_pkg::ADDR_CON1, 32'h0);
		axi_rd(crcc_pkg::ADDR_CON1);
		chk(rv, 32'h0000_0040);
		axi_wr(crcc_pkg::ADDR_CON1, 32'h0000_8000);
		axi_rd(crcc_pkg::ADDR_DATA);
		chk(rv, 32'h0);
	endtask
	// sel picks both the interrupt source and the bit order
	task automatic t_shift(input logic sel);
		axi_wr(crcc_pkg::ADDR_POLY, POLY);
		axi_rd(crcc_pkg::ADDR_POLY);
		chk(rv, POLY);
		axi_wr(crcc_pkg::ADDR_RESULT, 32'h0);
		e = 32'h8000;
		e[5] = sel;
		e[3] = sel;
		axi_wr(crcc_pkg::ADDR_CON1, e);
		axi_wr(crcc_pkg::ADDR_DATA, 32'hc3a5_0f01);
		axi_wr(crcc_pkg::ADDR_DATA, 32'h1234_5678);
		e[4] = 1'h1;
		axi_wr(crcc_pkg::ADDR_CON1, e);
		wait_go;
		e[4] = 1'h0;
		e[6] = 1'h1;
		chk(rv, e);
		axi_rd(crcc_pkg::ADDR_RESULT);
		chk(rv, ref_crc(ref_crc(32'h0, 32'hc3a5_0f01, sel), 32'h1234_5678, sel));
		axi_rd(crcc_pkg::ADDR_IRQ_STAT);
		chk(rv, 32'h1);
		chk({31'h0, irq}, 32'h1);
		axi_wr(crcc_pkg::ADDR_IRQ_STAT, 32'h1);
	endtask
	task automatic t_idle;
		idle_mode <= 1'h1;
		// stop-in-idle off: the engine keeps running while idle
		axi_wr(crcc_pkg::ADDR_DATA, 32'h0000_00ff);
		axi_wr(crcc_pkg::ADDR_CON1, 32'h0000_8030);
		wait_go;
		axi_rd(crcc_pkg::ADDR_IRQ_STAT);
		chk(rv, 32'h1);
		axi_wr(crcc_pkg::ADDR_IRQ_STAT, 32'h1);
		axi_wr(crcc_pkg::ADDR_DATA, 32'h0000_00ff);
		axi_wr(crcc_pkg::ADDR_CON1, 32'h0000_a030);
		// sixteen shift cycles plus load would finish well inside this
		repeat (40) @(posedge clk);
		axi_rd(crcc_pkg::ADDR_CON1);
		chk({31'h0, rv[4]}, 32'h1);
		axi_rd(crcc_pkg::ADDR_IRQ_STAT);
		chk(rv, 32'h0);
		idle_mode <= 1'h0;
		wait_go;
		axi_rd(crcc_pkg::ADDR_IRQ_STAT);
		chk(rv, 32'h1);
		axi_wr(crcc_pkg::ADDR_IRQ_STAT, 32'h1);
	endtask
	task automatic t_soft;
		axi_wr(crcc_pkg::ADDR_DATA, 32'h0000_5a5a);
		axi_wr(crcc_pkg::ADDR_CON1, 32'h0000_8030);
		axi_wr(crcc_pkg::ADDR_CON1, 32'h0000_8020);
		axi_rd(crcc_pkg::ADDR_IRQ_STAT);
		chk(rv, 32'h0);
		axi_wr(crcc_pkg::ADDR_CON1, 32'h0000_8030);
		wait_go;
		axi_rd(crcc_pkg::ADDR_IRQ_STAT);
		chk(rv, 32'h1);
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'h0;
		t_reset;
		t_fields;
		t_fill;
		t_shift(1'h0);
		t_shift(1'h1);
		t_idle;
		t_soft;
		print_verdict;
	end
endmodule
bind crcc_top crcc_monitor crcc_monitor_inst (.clk, .sys_rst, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .irq);
